//--- common/usf_pkg.sv
// constants for the uart status and flow threshold block
package usf_pkg;
	localparam logic [2:0] OFS_LSR_MSR  = 3'h5;
	localparam logic [2:0] OFS_MSR_TCR  = 3'h6;
	localparam logic [7:0] LCR_ENHANCED = 8'hBF;
	localparam logic [7:0] SRC_RESET    = 8'h00;
	localparam logic [7:0] TCR_RESET    = 8'h00;
	localparam int LSR_ERR_SUM  = 7;
	localparam int LSR_TX_IDLE  = 6;
	localparam int LSR_THR_EMPT = 5;
	localparam int LSR_BREAK    = 4;
	localparam int LSR_FRAMING  = 3;
	localparam int LSR_PARITY   = 2;
	localparam int LSR_OVERRUN  = 1;
	localparam int LSR_READY    = 0;
	localparam int MCR_DTR      = 0;
	localparam int MCR_RTS      = 1;
	localparam int MCR_OUT1_SEL = 2;
	localparam int MCR_OUT2     = 3;
	localparam int MCR_LOOP     = 4;
	localparam int EFR_ENH      = 4;
	localparam int SFR_ALT      = 2;
	localparam int THRESH_MULT_SHIFT = 2;
	localparam int ERR_BITS     = 3;
	localparam int FIFO_DEPTH   = 64;
	typedef enum logic [1:0] { FC_IDLE, FC_SEND_PAUSE, FC_PAUSED, FC_SEND_RESUME } usf_fc_state_t;
endpackage : usf_pkg

//--- core/usf_skid.sv
`timescale 1ns/10ps
// two-entry buffer with valid and ready on both sides
module usf_skid
	import usf_pkg::*;
#(
	parameter int WIDTH = 11
) (
	input  wire logic             clock_in,   // uart clock
	input  wire logic             reset_n_in, // async reset, low
	input  wire logic             in_valid_in, // word offered
	output logic                  in_ready_out, // room for a word
	input  wire logic [WIDTH-1:0] in_data_in, // offered word
	output logic                  out_valid_out, // word available
	input  wire logic             out_ready_in, // sink takes word
	output logic [WIDTH-1:0]      out_data_out  // oldest word
);
	logic [WIDTH-1:0] slot_reg [2];
	logic             rd_ptr_reg;
	logic             wr_ptr_reg;
	logic [1:0]       count_reg;
	wire              push = in_valid_in && in_ready_out;
	wire              pop  = out_valid_out && out_ready_in;

	assign in_ready_out  = (count_reg != 2'h2);
	assign out_valid_out = (count_reg != 2'h0);
	assign out_data_out  = slot_reg[rd_ptr_reg];

	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rd_ptr_reg <= 1'b0;
			wr_ptr_reg <= 1'b0;
			count_reg  <= 2'h0;
			slot_reg[0] <= '0;
			slot_reg[1] <= '0;
		end else begin
			if (push) begin
				slot_reg[wr_ptr_reg] <= in_data_in;
				wr_ptr_reg <= ~wr_ptr_reg;
			end
			if (pop)
				rd_ptr_reg <= ~rd_ptr_reg;
			count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
		end
	end
endmodule : usf_skid

//--- core/usf_status_flow.sv
`timescale 1ns/10ps
// uart line status, modem status and receive flow-control thresholds
// Notes on behaviour
// RQ1: bit 5 sets when holding byte moves out
// RQ2: bit 4 shows break of head character
// RQ3: bit 3 shows framing error of head
// RQ4: bit 2 shows parity error of head
// RQ5: bit 1 sets on arrival into full FIFO; the code sets it only when the two-entry buffer ahead of the FIFO is full too
// RQ6: bit 0 high while receive FIFO nonempty
// RQ7: second resume char at 5 when enhanced
// RQ8: second resume char cleared by power-on only
// RQ9: modem bits 7..4 are inverted input pins
// RQ10: loopback maps control bits 3,2,0,1 upward
// RQ11: change flags on carrier, ready, clear edges
// RQ12: ring flag only on low-to-high ring input
// RQ13: threshold register at 6 when gated, reset zero
// RQ14: auto request-to-send drops at halt level
// RQ15: pause character sent at halt level
// RQ16: auto request-to-send returns at resume level
// RQ17: resume character sent at resume level
// RQ18: software keeps resume below trigger level
// RQ19: software keeps halt above trigger level
// RQ20: bit 7 set while any stored error
// RQ21: errors are stored with each entry
// RQ22: reading modem status clears change flags
module usf_status_flow
	import usf_pkg::*;
#(
	parameter int DEPTH = FIFO_DEPTH,
	parameter int CW    = $clog2(FIFO_DEPTH + 1)
) (
	input  wire logic          clock_in,          // uart clock
	input  wire logic          reset_n_in,        // power-on reset, low
	input  wire logic          soft_reset_in,     // software reset pulse
	input  wire logic [2:0]    reg_addr_in,       // register offset
	input  wire logic          reg_wr_in,         // write strobe
	input  wire logic          reg_rd_in,         // read strobe
	input  wire logic [7:0]    reg_wdata_in,      // write data
	output logic [7:0]         reg_rdata_out,     // read data
	output logic               reg_hit_out,       // offset decoded here
	input  wire logic [7:0]    line_control_in,   // line control register
	input  wire logic [7:0]    modem_control_in,  // modem control register
	input  wire logic [7:0]    enhanced_features_in, // enhanced feature register
	input  wire logic [7:0]    special_features_in,  // special feature register
	input  wire logic          auto_rts_en_in,    // auto request-to-send on
	input  wire logic          auto_sw_flow_en_in, // auto pause/resume on
	input  wire logic          rx_valid_in,       // received character strobe
	input  wire logic [7:0]    rx_char_in,        // received character
	input  wire logic          rx_parity_err_in,  // bad parity
	input  wire logic          rx_framing_err_in, // no valid stop bit
	input  wire logic          rx_break_in,       // line low a whole frame
	output logic               rx_ready_out,      // buffer accepts character
	input  wire logic          rx_pop_in,         // software reads head
	output logic [7:0]         rx_head_out,       // head character
	input  wire logic          thr_to_tsr_in,     // holding byte moved to shifter
	input  wire logic          thr_write_in,      // software wrote holding reg
	input  wire logic          tx_idle_in,        // shifter and holding empty
	input  wire logic          carrier_detect_n_in, // carrier detect pin
	input  wire logic          ring_indicator_n_in, // ring pin
	input  wire logic          dsr_n_in,          // set-ready pin
	input  wire logic          cts_n_in,          // clear-to-send pin
	input  wire logic          msr_int_en_in,     // modem interrupt enable
	output logic               msr_int_out,       // modem status interrupt
	output logic               rts_n_out,         // request-to-send pin
	output logic               send_pause_out,    // request pause character
	output logic               send_resume_out,   // request resume character
	input  wire logic          flow_char_ack_in,  // transmitter took request
	output logic [7:0]         line_status_out,   // line status flags
	output logic [7:0]         modem_status_out   // modem input status
);
	localparam int EW = 8 + ERR_BITS;

	logic [7:0]    second_resume_char_reg;
	logic [7:0]    flow_levels_reg;
	logic [EW-1:0] fifo_reg [DEPTH];
	logic [CW-1:0] count_reg;
	logic [$clog2(DEPTH)-1:0] rd_idx_reg;
	logic [$clog2(DEPTH)-1:0] wr_idx_reg;
	logic [CW-1:0] err_count_reg;
	logic          overrun_reg;
	logic          thr_empty_reg;
	logic [3:0]    pin_meta_reg;
	logic [3:0]    pin_sync_reg;
	logic [3:0]    status_prev_reg;
	logic [3:0]    delta_reg;
	logic [3:0]    delta_next;
	logic          rts_hold_reg;
	usf_fc_state_t fc_state_reg;
	usf_fc_state_t fc_state_next;

	////////////////////////////////////////////////////////////////
	// register decode
	wire enh_sel   = (line_control_in == LCR_ENHANCED) && !special_features_in[SFR_ALT];
	wire tcr_sel   = enhanced_features_in[EFR_ENH] && modem_control_in[MCR_OUT1_SEL]
	                 && !special_features_in[SFR_ALT];
	wire std_sel   = !line_control_in[7];
	wire src_hit   = enh_sel && (reg_addr_in == OFS_LSR_MSR);   // RQ7
	wire tcr_hit   = !enh_sel && tcr_sel && (reg_addr_in == OFS_MSR_TCR); // RQ13
	wire lsr_hit   = !enh_sel && std_sel && (reg_addr_in == OFS_LSR_MSR);
	wire msr_hit   = !enh_sel && std_sel && !tcr_sel && (reg_addr_in == OFS_MSR_TCR);
	wire msr_read  = reg_rd_in && msr_hit;

	assign reg_hit_out   = src_hit || tcr_hit || lsr_hit || msr_hit;
	assign reg_rdata_out = src_hit ? second_resume_char_reg :
	                       tcr_hit ? flow_levels_reg :
	                       lsr_hit ? line_status_out :
	                       msr_hit ? modem_status_out : 8'h00;

	// the second resume character survives a software reset
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in)
			second_resume_char_reg <= SRC_RESET; // RQ8
		else if (reg_wr_in && src_hit)
			second_resume_char_reg <= reg_wdata_in; // RQ7
	end

	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in)
			flow_levels_reg <= TCR_RESET; // RQ13
		else if (soft_reset_in)
			flow_levels_reg <= TCR_RESET;
		else if (reg_wr_in && tcr_hit)
			flow_levels_reg <= reg_wdata_in;
	end

	////////////////////////////////////////////////////////////////
	// receive path: buffer, then fifo with per-entry error bits
	logic          buf_valid;
	logic [EW-1:0] buf_data;
	wire           fifo_full  = (count_reg == CW'(DEPTH));
	wire           fifo_empty = (count_reg == '0);
	wire           do_pop     = rx_pop_in && !fifo_empty;
	wire           do_push    = buf_valid && !fifo_full && !soft_reset_in;
	wire [EW-1:0]  head       = fifo_reg[rd_idx_reg];
	wire           head_err   = |head[EW-1:8];
	wire           in_err     = |buf_data[EW-1:8];
	wire           overrun_ev = rx_valid_in && !rx_ready_out;

	usf_skid #(.WIDTH(EW)) rx_buf (
		.clock_in     (clock_in),
		.reset_n_in   (reset_n_in),
		.in_valid_in  (rx_valid_in),
		.in_ready_out (rx_ready_out),
		.in_data_in   ({rx_break_in, rx_framing_err_in, rx_parity_err_in, rx_char_in}), // RQ21
		.out_valid_out(buf_valid),
		.out_ready_in (!fifo_full),
		.out_data_out (buf_data)
	);

	always_ff @(posedge clock_in) begin
		if (do_push)
			fifo_reg[wr_idx_reg] <= buf_data; // RQ21
	end

	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			count_reg     <= '0;
			rd_idx_reg    <= '0;
			wr_idx_reg    <= '0;
			err_count_reg <= '0;
		end else if (soft_reset_in) begin
			count_reg     <= '0;
			rd_idx_reg    <= '0;
			wr_idx_reg    <= '0;
			err_count_reg <= '0;
		end else begin
			if (do_push)
				wr_idx_reg <= wr_idx_reg + 1'b1;
			if (do_pop)
				rd_idx_reg <= rd_idx_reg + 1'b1;
			count_reg     <= count_reg + CW'(do_push) - CW'(do_pop);
			err_count_reg <= err_count_reg + CW'(do_push && in_err) - CW'(do_pop && head_err); // RQ20
		end
	end

	// overrun: set wins over the read that clears it
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in)
			overrun_reg <= 1'b0;
		else if (overrun_ev)
			overrun_reg <= 1'b1; // RQ5
		else if (soft_reset_in || (reg_rd_in && lsr_hit))
			overrun_reg <= 1'b0;
	end

	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in)
			thr_empty_reg <= 1'b1;
		else if (thr_to_tsr_in)
			thr_empty_reg <= 1'b1; // RQ1
		else if (thr_write_in || soft_reset_in)
			thr_empty_reg <= soft_reset_in;
	end

	assign rx_head_out = head[7:0];

	always_comb begin
		line_status_out               = 8'h00;
		line_status_out[LSR_ERR_SUM]  = (err_count_reg != '0);           // RQ20
		line_status_out[LSR_TX_IDLE]  = tx_idle_in;
		line_status_out[LSR_THR_EMPT] = thr_empty_reg;                   // RQ1
		line_status_out[LSR_BREAK]    = !fifo_empty && head[10];        // RQ2
		line_status_out[LSR_FRAMING]  = !fifo_empty && head[9];         // RQ3
		line_status_out[LSR_PARITY]   = !fifo_empty && head[8];         // RQ4
		line_status_out[LSR_OVERRUN]  = overrun_reg;                     // RQ5
		line_status_out[LSR_READY]    = !fifo_empty;                     // RQ6
	end

	////////////////////////////////////////////////////////////////
	// modem inputs: order is carrier, ring, set-ready, clear-to-send
	wire       loop   = modem_control_in[MCR_LOOP];
	wire [3:0] status = loop ? {modem_control_in[MCR_OUT2], modem_control_in[MCR_OUT1_SEL],
	                            modem_control_in[MCR_DTR], modem_control_in[MCR_RTS]} // RQ10
	                         : ~pin_sync_reg;                                         // RQ9
	wire [3:0] change = status ^ status_prev_reg;

	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			pin_meta_reg    <= 4'hF;
			pin_sync_reg    <= 4'hF;
			status_prev_reg <= 4'h0;
			delta_reg       <= 4'h0;
		end else begin
			pin_meta_reg    <= {carrier_detect_n_in, ring_indicator_n_in, dsr_n_in, cts_n_in};
			pin_sync_reg    <= pin_meta_reg;
			status_prev_reg <= status;
			delta_reg       <= soft_reset_in ? 4'h0 : delta_next;
		end
	end

	// ring status high means the pin went low; a pin rise is a status fall
	always_comb begin
		delta_next    = msr_read ? 4'h0 : delta_reg; // RQ22
		delta_next[3] = delta_next[3] | change[3];   // RQ11
		delta_next[2] = delta_next[2] | (status_prev_reg[2] && !status[2]); // RQ12
		delta_next[1] = delta_next[1] | change[1];   // RQ11
		delta_next[0] = delta_next[0] | change[0];   // RQ11
	end

	assign modem_status_out = {status, delta_reg};
	assign msr_int_out      = msr_int_en_in && (delta_reg != 4'h0); // RQ11

	a_msr_read_clear: assert property (@(posedge clock_in) disable iff (!reset_n_in)
		msr_read && (change == 4'h0) |=> (delta_reg == 4'h0)) else $error("modem flags not cleared by read"); // RQ22
	a_ring_rise_only: assert property (@(posedge clock_in) disable iff (!reset_n_in)
		!msr_read && !soft_reset_in && !delta_reg[2] && !$fell(status[2]) |=> !delta_reg[2] || $past(status_prev_reg[2]))
		else $error("ring flag without rising pin"); // RQ12
	a_cts_change_flag: assert property (@(posedge clock_in) disable iff (!reset_n_in)
		change[0] && !soft_reset_in |=> delta_reg[0]) else $error("clear-to-send change lost"); // RQ11
	a_loop_mapping: assert property (@(posedge clock_in) disable iff (!reset_n_in)
		loop |-> modem_status_out[7:4] == {modem_control_in[3], modem_control_in[2], modem_control_in[0],
		modem_control_in[1]}) else $error("loopback mapping wrong"); // RQ10

	////////////////////////////////////////////////////////////////
	// flow control thresholds
	wire [CW+1:0] halt_lvl   = (CW+2)'(flow_levels_reg[3:0]) << THRESH_MULT_SHIFT;
	wire [CW+1:0] resume_lvl = (CW+2)'(flow_levels_reg[7:4]) << THRESH_MULT_SHIFT;
	wire [CW+1:0] cnt_wide   = (CW+2)'(count_reg);
	wire          at_halt    = cnt_wide >= halt_lvl;   // RQ14
	wire          at_resume  = cnt_wide <= resume_lvl; // RQ16

	// rts keeps its last level between the two thresholds (hysteresis)
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in)
			rts_hold_reg <= 1'b0;
		else if (!auto_rts_en_in || soft_reset_in)
			rts_hold_reg <= 1'b0;
		else if (at_halt)
			rts_hold_reg <= 1'b1; // RQ14
		else if (at_resume)
			rts_hold_reg <= 1'b0; // RQ16
	end

	assign rts_n_out = auto_rts_en_in ? rts_hold_reg : !modem_control_in[MCR_RTS];

	always_comb begin
		fc_state_next = fc_state_reg;
		case (fc_state_reg)
			FC_IDLE:        if (at_halt) fc_state_next = FC_SEND_PAUSE;          // RQ15
			FC_SEND_PAUSE:  if (flow_char_ack_in) fc_state_next = FC_PAUSED;
			FC_PAUSED:      if (at_resume) fc_state_next = FC_SEND_RESUME;       // RQ17
			FC_SEND_RESUME: if (flow_char_ack_in) fc_state_next = FC_IDLE;
			default:        fc_state_next = FC_IDLE;
		endcase
	end

	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in)
			fc_state_reg <= FC_IDLE;
		else if (!auto_sw_flow_en_in || soft_reset_in)
			fc_state_reg <= FC_IDLE;
		else
			fc_state_reg <= fc_state_next;
	end

	assign send_pause_out  = (fc_state_reg == FC_SEND_PAUSE);  // RQ15
	assign send_resume_out = (fc_state_reg == FC_SEND_RESUME); // RQ17

	a_rts_halt_drop: assert property (@(posedge clock_in) disable iff (!reset_n_in)
		auto_rts_en_in && !soft_reset_in && at_halt |=> auto_rts_en_in |-> rts_n_out) else $error("rts not dropped"); // RQ14
	a_rts_resume_up: assert property (@(posedge clock_in) disable iff (!reset_n_in)
		auto_rts_en_in && !soft_reset_in && !at_halt && at_resume ##1 auto_rts_en_in |-> !rts_n_out)
		else $error("rts not reasserted"); // RQ16
	a_pause_request: assert property (@(posedge clock_in) disable iff (!reset_n_in)
		auto_sw_flow_en_in && !soft_reset_in && fc_state_reg == FC_IDLE && at_halt ##1 auto_sw_flow_en_in
		|-> send_pause_out) else $error("pause not requested"); // RQ15
	a_ready_empty: assert property (@(posedge clock_in) disable iff (!reset_n_in)
		line_status_out[LSR_READY] == (count_reg != '0)) else $error("data ready mismatch"); // RQ6
	a_overrun_set: assert property (@(posedge clock_in) disable iff (!reset_n_in)
		overrun_ev |=> overrun_reg) else $error("overrun missed"); // RQ5
	a_src_keep: assert property (@(posedge clock_in) disable iff (!reset_n_in)
		soft_reset_in && !(reg_wr_in && src_hit) |=> $stable(second_resume_char_reg))
		else $error("resume char lost on soft reset"); // RQ8
	a_err_summary: assert property (@(posedge clock_in) disable iff (!reset_n_in)
		!fifo_empty && head_err |-> line_status_out[LSR_ERR_SUM]) else $error("error summary low"); // RQ20
endmodule : usf_status_flow

//--- test/usf_remote_dev.sv
// remote serial device model: offers received characters and drives the modem pins
`timescale 1ns/10ps
module usf_remote_dev (
	input  wire logic  clock_in,     // uart clock
	input  wire logic  rx_ready_in,  // block accepts a character
	output logic       rx_valid_out, // character offered
	output logic [7:0] rx_char_out,  // character
	output logic [2:0] rx_err_out,   // break, framing, parity
	output logic [3:0] pins_n_out    // carrier, ring, set-ready, clear-to-send
);
	initial begin
		rx_valid_out = 1'b0;
		rx_char_out = 8'h00;
		rx_err_out = 3'h0;
		pins_n_out = 4'hF;
	end
	// a real far end may keep sending into a full buffer; ign_rdy models that on command
	task automatic send(input logic [7:0] ch, input logic [2:0] err, input bit ign_rdy);
		@(negedge clock_in);
		rx_valid_out = 1'b1;
		rx_char_out = ch;
		rx_err_out = err;
		while (!ign_rdy && rx_ready_in !== 1'b1)
			@(negedge clock_in);
		@(negedge clock_in);
		rx_valid_out = 1'b0;
		// released lines show the inverse so a stale value is never mistaken for data
		rx_char_out = ~ch;
		rx_err_out = ~err;
	endtask : send
	task automatic set_pins(input logic [3:0] p);
		@(negedge clock_in);
		pins_n_out = p;
	endtask : set_pins
endmodule : usf_remote_dev

//--- test/testbench.sv
// self-checking bench for the uart status and flow threshold block
`timescale 1ns/10ps
module testbench;
	import usf_pkg::*;
	logic clock_in, reset_n_in, soft_reset_in, reg_wr_in, reg_rd_in, reg_hit_out, auto_rts_en_in;
	logic auto_sw_flow_en_in, rx_ready_out, rx_pop_in, thr_to_tsr_in, thr_write_in, tx_idle_in;
	logic msr_int_en_in, msr_int_out, rts_n_out, send_pause_out, send_resume_out, flow_char_ack_in;
	logic rx_valid;
	logic [2:0] reg_addr_in, rx_err;
	logic [3:0] pins_n;
	logic [7:0] reg_wdata_in, reg_rdata_out, line_control_in, modem_control_in, enhanced_features_in;
	logic [7:0] special_features_in, rx_char, rx_head_out, line_status_out, modem_status_out, d;
	int n_fail, checked, cycles;

	usf_status_flow usf_status_flow_i (.clock_in, .reset_n_in, .soft_reset_in, .reg_addr_in, .reg_wr_in,
		.reg_rd_in, .reg_wdata_in, .reg_rdata_out, .reg_hit_out, .line_control_in, .modem_control_in,
		.enhanced_features_in, .special_features_in, .auto_rts_en_in, .auto_sw_flow_en_in,
		.rx_valid_in(rx_valid), .rx_char_in(rx_char), .rx_parity_err_in(rx_err[0]),
		.rx_framing_err_in(rx_err[1]), .rx_break_in(rx_err[2]), .rx_ready_out, .rx_pop_in, .rx_head_out,
		.thr_to_tsr_in, .thr_write_in, .tx_idle_in, .carrier_detect_n_in(pins_n[3]),
		.ring_indicator_n_in(pins_n[2]), .dsr_n_in(pins_n[1]), .cts_n_in(pins_n[0]), .msr_int_en_in,
		.msr_int_out, .rts_n_out, .send_pause_out, .send_resume_out, .flow_char_ack_in, .line_status_out,
		.modem_status_out);
	usf_remote_dev usf_remote_dev_i (.clock_in, .rx_ready_in(rx_ready_out), .rx_valid_out(rx_valid),
		.rx_char_out(rx_char), .rx_err_out(rx_err), .pins_n_out(pins_n));

	initial begin
		clock_in = 1'b0;
		forever #5 clock_in = ~clock_in;
	end
	always @(posedge clock_in) begin
		cycles++;
		if (cycles == 6000) begin
			n_fail++;
			final_report();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %0t %s: seen %h expected %h", $time, msg, seen, exp);
		end
	endtask : check
	task automatic final_report();
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : final_report
	task automatic tick(input int n);
		repeat (n) @(negedge clock_in);
	endtask : tick
	task automatic rd(input logic [2:0] a);
		@(negedge clock_in);
		reg_addr_in = a;
		reg_rd_in = 1'b1;
		#1;
		d = reg_rdata_out;
		@(negedge clock_in);
		reg_rd_in = 1'b0;
	endtask : rd
	task automatic wr(input logic [2:0] a, input logic [7:0] v);
		@(negedge clock_in);
		reg_addr_in = a;
		reg_wdata_in = v;
		reg_wr_in = 1'b1;
		@(negedge clock_in);
		reg_wr_in = 1'b0;
	endtask : wr
	task automatic pop();
		@(negedge clock_in);
		rx_pop_in = 1'b1;
		@(negedge clock_in);
		rx_pop_in = 1'b0;
	endtask : pop
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_regs();
		line_control_in = LCR_ENHANCED;
		rd(OFS_LSR_MSR);
		check(d, SRC_RESET, "resume char reset");
		wr(OFS_LSR_MSR, 8'hA5);
		rd(OFS_LSR_MSR);
		check(d, 8'hA5, "resume char rw");
		special_features_in = 8'h04;
		rd(OFS_LSR_MSR);
		check({7'h0, reg_hit_out}, 8'h00, "resume char hidden");
		special_features_in = 8'h00;
		line_control_in = 8'h00;
		rd(OFS_LSR_MSR);
		check(d, 8'h60, "line status at offset 5");
		@(negedge clock_in);
		soft_reset_in = 1'b1;
		@(negedge clock_in);
		soft_reset_in = 1'b0;
		line_control_in = LCR_ENHANCED;
		rd(OFS_LSR_MSR);
		check(d, 8'hA5, "resume char kept");
		line_control_in = 8'h00;
		enhanced_features_in = 8'h10;
		modem_control_in = 8'h04;
		rd(OFS_MSR_TCR);
		check(d, TCR_RESET, "levels reset");
		wr(OFS_MSR_TCR, 8'h21);
		rd(OFS_MSR_TCR);
		check(d, 8'h21, "levels rw");
		modem_control_in = 8'h00;
		rd(OFS_MSR_TCR);
		check(d, 8'h00, "modem status at offset 6");
		rd(3'h3);
		check({reg_hit_out, d[6:0]}, 8'h00, "unmapped offset");
		$display("test regs done");
	endtask : t_regs
	task automatic t_tx();
		@(negedge clock_in);
		thr_write_in = 1'b1;
		@(negedge clock_in);
		thr_write_in = 1'b0;
		tx_idle_in = 1'b0;
		tick(1);
		check(line_status_out & 8'h60, 8'h00, "holding busy");
		thr_to_tsr_in = 1'b1;
		@(negedge clock_in);
		thr_to_tsr_in = 1'b0;
		tx_idle_in = 1'b1;
		tick(1);
		check(line_status_out & 8'h60, 8'h60, "holding empty");
		$display("test tx done");
	endtask : t_tx
	task automatic t_rx_err();
		logic [7:0] hd[4] = '{8'h11, 8'h22, 8'h33, 8'h44};
		logic [7:0] ls[4] = '{8'h85, 8'h89, 8'h91, 8'h01};
		for (int i = 0; i < 4; i++)
			usf_remote_dev_i.send(hd[i], 3'(i == 3 ? 0 : 1 << i), 1'b0);
		tick(4);
		for (int i = 0; i < 4; i++) begin
			check(rx_head_out, hd[i], "head char");
			check(line_status_out & 8'h9D, ls[i], "head errors");
			pop();
		end
		check(line_status_out & 8'h9D, 8'h00, "fifo empty");
		$display("test rx errors done");
	endtask : t_rx_err
	task automatic t_modem();
		logic [3:0] pv[3] = '{4'hE, 4'h2, 4'h4};
		logic [7:0] mv[3] = '{8'h11, 8'hD8, 8'hB6};
		msr_int_en_in = 1'b1;
		for (int i = 0; i < 3; i++) begin
			usf_remote_dev_i.set_pins(pv[i]);
			tick(5);
			check(modem_status_out, mv[i], "pin status");
			check({7'h0, msr_int_out}, 8'h01, "modem interrupt");
			rd(OFS_MSR_TCR);
			check(modem_status_out, mv[i] & 8'hF0, "deltas cleared");
		end
		msr_int_en_in = 1'b0;
		modem_control_in = 8'h1D;
		tick(5);
		check({modem_status_out[7:4], 3'h0, msr_int_out}, 8'hE0, "loop outputs");
		modem_control_in = 8'h12;
		tick(5);
		check(modem_status_out & 8'hF0, 8'h10, "loop request");
		modem_control_in = 8'h00;
		usf_remote_dev_i.set_pins(4'hF);
		tick(5);
		rd(OFS_MSR_TCR);
		$display("test modem done");
	endtask : t_modem
	task automatic t_flow();
		enhanced_features_in = 8'h10;
		modem_control_in = 8'h04;
		wr(OFS_MSR_TCR, 8'h12);
		auto_rts_en_in = 1'b1;
		auto_sw_flow_en_in = 1'b1;
		tick(2);
		check({7'h0, rts_n_out}, 8'h00, "rts at empty");
		for (int i = 0; i < 7; i++)
			usf_remote_dev_i.send(8'(i), 3'h0, 1'b0);
		tick(4);
		check({6'h0, rts_n_out, send_pause_out}, 8'h00, "below halt");
		usf_remote_dev_i.send(8'h07, 3'h0, 1'b0);
		tick(4);
		check({6'h0, rts_n_out, send_pause_out}, 8'h03, "at halt");
		flow_char_ack_in = 1'b1;
		@(negedge clock_in);
		flow_char_ack_in = 1'b0;
		repeat (3) pop();
		tick(1);
		check({6'h0, rts_n_out, send_pause_out}, 8'h02, "above resume");
		pop();
		tick(1);
		check({6'h0, rts_n_out, send_resume_out}, 8'h01, "at resume");
		flow_char_ack_in = 1'b1;
		@(negedge clock_in);
		flow_char_ack_in = 1'b0;
		tick(1);
		check({7'h0, send_resume_out}, 8'h00, "resume taken");
		repeat (4) pop();
		$display("test flow done");
	endtask : t_flow
	task automatic t_overrun();
		for (int i = 0; i < FIFO_DEPTH + 2; i++)
			usf_remote_dev_i.send(8'(i), 3'h0, 1'b0);
		tick(3);
		check({7'h0, rx_ready_out}, 8'h00, "buffer full");
		usf_remote_dev_i.send(8'hEE, 3'h0, 1'b1);
		tick(2);
		check(line_status_out & 8'h03, 8'h03, "overrun");
		rd(OFS_LSR_MSR);
		tick(1);
		check(line_status_out & 8'h03, 8'h01, "overrun read");
		for (int i = 0; i < FIFO_DEPTH + 2; i++) begin
			check(rx_head_out, 8'(i), "drain order");
			pop();
		end
		tick(1);
		check({line_status_out[0], 6'h0, rx_ready_out}, 8'h01, "drained");
		$display("test overrun done");
	endtask : t_overrun
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{soft_reset_in, reg_wr_in, reg_rd_in, auto_rts_en_in, auto_sw_flow_en_in, rx_pop_in} = '0;
		{thr_to_tsr_in, thr_write_in, msr_int_en_in, flow_char_ack_in, reg_addr_in, reg_wdata_in} = '0;
		{line_control_in, modem_control_in, enhanced_features_in, special_features_in} = '0;
		tx_idle_in = 1'b1;
		reset_n_in = 1'b0;
		tick(8);
		reset_n_in = 1'b1;
		tick(2);
		t_regs();
		t_tx();
		t_rx_err();
		t_modem();
		t_flow();
		t_overrun();
		final_report();
	end
endmodule : testbench
